// ==== logic/adc_conv_pkg.sv ====
// Types shared by the converter control block
package adc_conv_pkg;
`include "adc_conv_regs.svh"

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic [`RESULT_BITS-1:0] code;
  } sample_t;

  typedef struct packed {
    conv_state_t state;
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic cs_prev;
    logic sclk_prev;
    logic [`CONV_BITS-1:0] shreg;
    logic [`RESULT_BITS-1:0] word;
    logic [`BIT_CNT_W-1:0] bitcnt;
    logic [`GAP_CNT_W-1:0] gap_cnt;
    logic [`WAKE_CNT_W-1:0] wake_cnt;
    logic oe_n;
    logic dout;
    logic frame_done;
    logic missing;
    logic early;
  } conv_regs_t;

endpackage

// ==== logic/adc_conv_regs.svh ====
// Timing and framing constants of the serial converter interface
`ifndef ADC_CONV_REGS_SVH
`define ADC_CONV_REGS_SVH

`define CLK_PERIOD_NS 100
`define CONV_BITS 16
`define LEAD_ZEROS 4
`define RESULT_BITS 12
`define BIT_CNT_W 4
`define LAST_BIT 4'hF
`define FIFO_WORDS 8

`define T_QUIET_NS 100
`define T_ACQ_NS 300
`define T_ENABLE_NS 22
`define T_ACCESS_NS 40
`define T_RELMIN_NS 10
`define T_RELMAX_NS 45
`define T_CSREL_NS 20
`define T_WAKE_EXT_NS 20000
`define T_WAKE_INT_NS 650000

// Least times round up, longest times round down, never below one cycle
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns) ((((ns) / `CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `CLK_PERIOD_NS))
`define QUIET_CYC `CYC_UP(`T_QUIET_NS)
`define ACQ_CYC `CYC_UP(`T_ACQ_NS)
`define GAP_CNT_W 4
`define WAKE_CNT_W 16

`endif

// ==== logic/adc_serial_conversion_timing.sv ====
// Conversion framing and serial read-out of a 12-bit converter
`timescale 1ns/10ps
module adc_serial_conversion_timing
  import adc_conv_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_WORDS,
  parameter int WAKE_NS = `T_WAKE_INT_NS,
  parameter int WAKE_CYCLES = `CYC_UP(WAKE_NS)
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic conv_sel_n_in,
  input wire logic sclk_in,
  input wire logic sample_valid_in,
  input wire sample_t sample_in,
  output logic sample_ready_out,
  output logic result_out,
  output logic result_oe_n_out,
  output logic busy_out,
  output logic frame_done_out,
  output logic missing_out,
  output logic early_start_out,
  output logic quiet_ok_out,
  output logic wake_done_out
);
  localparam logic [`GAP_CNT_W-1:0] ACQ_GAP = `GAP_CNT_W'(`ACQ_CYC);
  localparam logic [`GAP_CNT_W-1:0] QUIET_GAP = `GAP_CNT_W'(`QUIET_CYC);

  conv_regs_t st_ff;
  conv_regs_t nxt_st;
  sample_t fifo_word;
  logic fifo_valid;
  logic fifo_pop;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;

  // Zero-padded frame, most significant bit leaves first
  function automatic logic [`CONV_BITS-1:0] frame_word(input logic [`RESULT_BITS-1:0] code);
    frame_word = {`LEAD_ZEROS'(0), code};
  endfunction

  sample_fifo #(
    .WIDTH($bits(sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(sample_valid_in),
    .in_ready_out(sample_ready_out),
    .in_data_in(sample_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_word)
  );

  // Edges seen on the second synchroniser stage only
  assign cs_fall = st_ff.cs_prev & ~st_ff.cs_sync[1];
  assign cs_rise = ~st_ff.cs_prev & st_ff.cs_sync[1];
  assign sclk_fall = st_ff.sclk_prev & ~st_ff.sclk_sync[1];
  assign fifo_pop = cs_fall & (st_ff.state != ST_SHIFT);

  // Whole next state of the block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.cs_sync = {st_ff.cs_sync[0], conv_sel_n_in};
    nxt_st.sclk_sync = {st_ff.sclk_sync[0], sclk_in};
    nxt_st.cs_prev = st_ff.cs_sync[1];
    nxt_st.sclk_prev = st_ff.sclk_sync[1];
    nxt_st.frame_done = 1'b0;
    nxt_st.missing = 1'b0;
    nxt_st.early = 1'b0;
    // Wake wait only reports; gating results is left to the host
    if (st_ff.wake_cnt != '0) begin
      nxt_st.wake_cnt = st_ff.wake_cnt - `WAKE_CNT_W'(1);
    end
    if (st_ff.gap_cnt < ACQ_GAP) begin
      nxt_st.gap_cnt = st_ff.gap_cnt + `GAP_CNT_W'(1);
    end
    case (st_ff.state)
      ST_IDLE, ST_DONE: begin
        if (cs_fall) begin
          // Start conversion and take the line; an empty FIFO sends zeros
          nxt_st.state = ST_SHIFT;
          nxt_st.word = fifo_valid ? fifo_word.code : '0;
          nxt_st.shreg = frame_word(fifo_valid ? fifo_word.code : '0);
          nxt_st.dout = 1'b0;
          nxt_st.oe_n = 1'b0;
          nxt_st.bitcnt = '0;
          nxt_st.missing = ~fifo_valid;
          nxt_st.early = (st_ff.gap_cnt < ACQ_GAP);
        end else if (cs_rise) begin
          nxt_st.state = ST_IDLE;
        end
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          // Select wins over a coincident clock edge
          nxt_st.oe_n = 1'b1;
          nxt_st.state = ST_IDLE;
          nxt_st.gap_cnt = '0;
        end else if (sclk_fall) begin
          if (st_ff.bitcnt == `LAST_BIT) begin
            nxt_st.oe_n = 1'b1;
            nxt_st.state = ST_DONE;
            nxt_st.frame_done = 1'b1;
            nxt_st.gap_cnt = '0;
          end else begin
            nxt_st.shreg = {st_ff.shreg[`CONV_BITS-2:0], 1'b0};
            nxt_st.dout = st_ff.shreg[`CONV_BITS-2];
            nxt_st.bitcnt = st_ff.bitcnt + `BIT_CNT_W'(1);
          end
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
        nxt_st.oe_n = 1'b1;
      end
    endcase
  end

  // Synchronisers idle high so no false start follows reset
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '{state: ST_IDLE, cs_sync: 2'h3, sclk_sync: 2'h3, cs_prev: 1'b1,
                 sclk_prev: 1'b1, shreg: '0, word: '0, bitcnt: '0,
                 gap_cnt: `GAP_CNT_W'(`ACQ_CYC), wake_cnt: `WAKE_CNT_W'(WAKE_CYCLES),
                 oe_n: 1'b1, dout: 1'b0, frame_done: 1'b0, missing: 1'b0, early: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // All outputs straight from flip-flops, apart from decoded levels
  assign result_out = st_ff.dout;
  assign result_oe_n_out = st_ff.oe_n;
  assign busy_out = (st_ff.state == ST_SHIFT);
  assign frame_done_out = st_ff.frame_done;
  assign missing_out = st_ff.missing;
  assign early_start_out = st_ff.early;
  assign quiet_ok_out = (st_ff.gap_cnt >= ACQ_GAP) && (st_ff.gap_cnt >= QUIET_GAP);
  assign wake_done_out = (st_ff.wake_cnt == '0);

  sequence s_start;
    cs_fall && (st_ff.state != ST_SHIFT);
  endsequence

  sequence s_last_edge;
    busy_out && !cs_rise && sclk_fall && (st_ff.bitcnt == `LAST_BIT);
  endsequence

  a_enable_on_select: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_start |=> !result_oe_n_out && busy_out && (result_out == 1'b0))
    else $error("data line not driven after select fell");

  a_release_on_deselect: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (busy_out && cs_rise) |=> result_oe_n_out && !busy_out)
    else $error("data line still driven after select rose");

  a_release_last_edge: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_last_edge |=> result_oe_n_out && frame_done_out ##1 !frame_done_out)
    else $error("data line not released after last edge");

  a_bit_per_edge: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (busy_out && !cs_rise && sclk_fall && (st_ff.bitcnt != `LAST_BIT))
    |=> busy_out && (st_ff.bitcnt == $past(st_ff.bitcnt) + `BIT_CNT_W'(1)))
    else $error("bit count did not advance on a falling edge");

  a_bit_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (busy_out && !sclk_fall && !cs_rise) |=> $stable(result_out) && !result_oe_n_out)
    else $error("data changed without a falling edge");

  a_lead_zeros: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (busy_out && (st_ff.bitcnt < `BIT_CNT_W'(`LEAD_ZEROS))) |-> (result_out == 1'b0))
    else $error("leading bit not zero");

  a_msb_first: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (busy_out && (st_ff.bitcnt >= `BIT_CNT_W'(`LEAD_ZEROS)))
    |-> (result_out == st_ff.word[`LAST_BIT - st_ff.bitcnt]))
    else $error("result bit out of order");

  a_pop_on_start: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (s_start and (fifo_valid && !cs_rise)) |-> fifo_pop ##1 (st_ff.word == $past(fifo_word.code)))
    else $error("start did not take a sample");

  a_early_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (s_start and (st_ff.gap_cnt < ACQ_GAP)) |=> early_start_out ##1 !early_start_out)
    else $error("early start not flagged");

  // A start after a full gap must stay unflagged, or the host sees false alarms
  a_no_false_early: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (s_start and (st_ff.gap_cnt >= ACQ_GAP)) |=> !early_start_out)
    else $error("start flagged early after a full gap");

  // Outside a frame the line must never be driven
  a_idle_released: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !busy_out |-> result_oe_n_out)
    else $error("data line driven outside a frame");

  // Empty queue at start sends zeros and pulses the flag once
  a_missing_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (s_start and !fifo_valid) |=> missing_out && (result_out == 1'b0) ##1 !missing_out)
    else $error("empty start not flagged");

  // Gap count restarts at a normal end of frame
  a_gap_after_frame: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    s_last_edge |=> !quiet_ok_out)
    else $error("quiet reported right after frame end");

  // Gap count restarts at an aborted frame as well
  a_gap_after_abort: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (busy_out && cs_rise) |=> !quiet_ok_out)
    else $error("quiet reported right after abort");

  // Wake report never drops once raised
  a_wake_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    wake_done_out |=> wake_done_out)
    else $error("wake report dropped");
endmodule

// ==== logic/sample_fifo.sv ====
// Small synchronous FIFO for conversion results
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_regs_t;

  fifo_regs_t st_ff;
  fifo_regs_t nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign in_ready_out = (st_ff.count != (AW+1)'(DEPTH));
  assign out_valid_out = (st_ff.count != '0);
  assign out_data_out = mem_ff[st_ff.rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Pointer and count update
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wr_ptr = ptr_inc(st_ff.wr_ptr);
    end
    if (pop) begin
      nxt_st.rd_ptr = ptr_inc(st_ff.rd_ptr);
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_ff[st_ff.wr_ptr] <= in_data_in;
    end
  end
endmodule

// ==== sim/adc_serial_conversion_timing_tb.sv ====
// Self-checking bench for the converter serial read-out block
`timescale 1ns/10ps
module adc_serial_conversion_timing_tb;
  import adc_conv_pkg::*;
  logic core_clk, rst_n, sel_n, sclk, sample_valid, ready, result, oe_n;
  logic busy, frame_done, missing, early, quiet_ok, wake_done;
  sample_t sample;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int frame_cnt = 0;
  int missing_cnt = 0;
  int early_cnt = 0;
  // Short wake count keeps the run brief
  adc_serial_conversion_timing #(.WAKE_CYCLES(5)) dut (.core_clk_in(core_clk), .rst_n_in(rst_n),
    .conv_sel_n_in(sel_n), .sclk_in(sclk), .sample_valid_in(sample_valid), .sample_in(sample),
    .sample_ready_out(ready), .result_out(result), .result_oe_n_out(oe_n), .busy_out(busy),
    .frame_done_out(frame_done), .missing_out(missing), .early_start_out(early),
    .quiet_ok_out(quiet_ok), .wake_done_out(wake_done));
  host_model host (.core_clk_in(core_clk), .result_in(result), .result_oe_n_in(oe_n),
    .conv_sel_n_out(sel_n), .sclk_out(sclk));
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  // Pulses are counted at the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    if (frame_done === 1'b1) frame_cnt++;
    if (missing === 1'b1) missing_cnt++;
    if (early === 1'b1) early_cnt++;
  end
  // Hang guard: about six times the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [11:0] code_of(input int i);
    return 12'h5A3 ^ 12'(i * 12'h111);
  endfunction
  task automatic push(input logic [11:0] code);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    sample.code <= code;
    @(posedge core_clk);
    sample_valid <= 1'b0;
  endtask
  // Reset values, then the wake wait counted from release
  task automatic t_reset();
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    check("oe_n_reset", oe_n, 1'b1);
    check("wake_reset", wake_done, 1'b0);
    check("ready_reset", ready, 1'b1);
    check("quiet_reset", quiet_ok, 1'b1);
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check("wake_early", wake_done, 1'b0);
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    check("wake_done", wake_done, 1'b1);
  endtask
  // Back-to-back fill until refused, then drain oldest first through full frames
  task automatic t_fill_drain();
    logic [15:0] w;
    @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      sample_valid <= 1'b1;
      sample.code <= code_of(i);
      @(posedge core_clk);
    end
    sample_valid <= 1'b0;
    @(negedge core_clk);
    check("ready_full", ready, 1'b0);
    for (int i = 0; i < 8; i++) begin
      host.frame(16, w);
      check("word", w, {4'h0, code_of(i)});
      check("released", oe_n, 1'b1);
      check("busy_end", busy, 1'b0);
      check("frames", 16'(frame_cnt), 16'(i + 1));
      host.finish(4);
    end
    check("no_early", 16'(early_cnt), 16'h0000);
  endtask
  // Frame with nothing queued sends zeros and flags it; the refused ninth word is absent
  task automatic t_empty();
    logic [15:0] w;
    host.frame(16, w);
    check("empty_word", w, 16'h0000);
    check("missing", 16'(missing_cnt), 16'h0001);
    host.finish(4);
  endtask
  // Select rise mid-frame releases the line; optionally restart at once
  task automatic t_abort(input bit quick);
    logic [15:0] w;
    int fc;
    push(12'hC3D);
    push(12'h8E1);
    host.frame(5, w);
    check("abort_bits", w, 16'h0001);
    check("driving", oe_n, 1'b0);
    check("busy_mid", busy, 1'b1);
    fc = frame_cnt;
    if (quick) begin
      host.finish(1);
      host.frame(16, w);
      check("early_word", w, {4'h0, 12'h8E1});
      check("early", 16'(early_cnt), 16'h0001);
      host.finish(4);
    end else begin
      host.finish(5);
      @(negedge core_clk);
      check("abort_rel", oe_n, 1'b1);
      check("abort_nodone", 16'(frame_cnt), 16'(fc));
      check("quiet_low", quiet_ok, 1'b0);
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      check("quiet_high", quiet_ok, 1'b1);
      host.frame(16, w);
      check("next_word", w, {4'h0, 12'h8E1});
      host.finish(4);
    end
  endtask
  initial begin
    rst_n = 1'b0;
    sample_valid = 1'b0;
    t_reset();
    t_fill_drain();
    t_empty();
    t_abort(1'b0);
    t_abort(1'b1);
    stop_test();
  end
endmodule

// ==== sim/host_model.sv ====
// Host serial master model: drives select and serial clock, reads the data line
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk_in,
  input wire logic result_in,
  input wire logic result_oe_n_in,
  output logic conv_sel_n_out,
  output logic sclk_out
);
  logic line;
  // A released line shows the inverse of the last driven bit, so stale bits never pass
  assign line = result_oe_n_in ? ~result_in : result_in;
  initial begin
    conv_sel_n_out = 1'b1;
    sclk_out = 1'b1;
  end
  // Lower select with the clock high, read each bit late in the high phase, then fall
  task automatic frame(input int nfall, output logic [15:0] word);
    word = 16'h0000;
    @(posedge core_clk_in);
    conv_sel_n_out <= 1'b0;
    @(posedge core_clk_in);
    for (int k = 0; k < nfall; k++) begin
      repeat (3) @(posedge core_clk_in);
      @(negedge core_clk_in);
      word = {word[14:0], line};
      @(posedge core_clk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge core_clk_in);
      sclk_out <= 1'b1;
    end
    // Clock stands still high outside frames
    repeat (4) @(posedge core_clk_in);
  endtask
  // Raise select, then keep quiet for the requested gap
  task automatic finish(input int gap);
    @(posedge core_clk_in);
    conv_sel_n_out <= 1'b1;
    repeat (gap) @(posedge core_clk_in);
  endtask
endmodule
